// File: cache_test_pkg.sv
/*
  shared constants for the cache test register block: register select codes,
  command and tag/status field layout, cache geometry, self-test timing.
  assumes a 25 MHz aclk on both ends.
*/
package cache_test_pkg;
  localparam int WORD_W = 32;
  localparam int SETS = 128;
  localparam int WAYS = 4;
  localparam int ENTRIES = 512;
  localparam int LINE_W = 128;
  localparam int TAG_W = 21;
  localparam int LRU_W = 3;
  localparam int SET_W = 7;
  localparam int ENT_W = 2;
  localparam int LOC_W = 9;
  localparam int TLB_ENTRIES = 32;
  localparam int TLB_W = 22;
  // test register select on the move port
  localparam logic [1:0] SEL_DATA = 2'h0;
  localparam logic [1:0] SEL_TAG = 2'h1;
  localparam logic [1:0] SEL_CMD = 2'h2;
  // command control field codes
  localparam logic [1:0] CTL_BUF = 2'h0;
  localparam logic [1:0] CTL_WRITE = 2'h1;
  localparam logic [1:0] CTL_READ = 2'h2;
  localparam logic [1:0] CTL_FLUSH = 2'h3;
  // command field positions
  localparam int CMD_CTL_LSB = 0;
  localparam int CMD_ENT_LSB = 2;
  localparam int CMD_SET_LSB = 4;
  // tag/status field positions
  localparam int TS_TAG_LSB = 11;
  localparam int TS_VALID_BIT = 10;
  localparam int TS_LRU_LSB = 7;
  localparam int TS_SETV_LSB = 3;
  // self-test timing
  localparam int ST_TIME_MS = 42;
  localparam int ST_REF_MHZ = 25;
  localparam int ST_CYCLES = ST_TIME_MS * 1000 * ST_REF_MHZ;
  localparam int CYC_W = 23;
  localparam int IDX_W = 10;
  localparam int LOGIC_STEPS = 256;
  localparam int RESEQ_CYCLES = 16;
  // flaw bits in the result word
  localparam int FLAW_LOGIC = 0;
  localparam int FLAW_ROM = 1;
  localparam int FLAW_CACHE = 2;
  localparam int FLAW_TLB = 3;
  localparam logic [31:0] PAT_A = 32'hA5A5A5A5;
  localparam logic [31:0] PAT_B = 32'h5A5A5A5A;
  localparam int ROM_WORDS = 4;
  localparam logic [31:0] ROM_IMG [ROM_WORDS] = '{32'h13579BDF, 32'h2468ACE0,
    32'hFEDCBA98, 32'h01234567};
  localparam logic [31:0] ROM_SIG = ROM_IMG[0] ^ ROM_IMG[1] ^ ROM_IMG[2] ^ ROM_IMG[3];
  // controller register map
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RESET = 8'h04;
  localparam logic [7:0] OFS_MOVE = 8'h08;
  localparam logic [7:0] OFS_WDATA = 8'h0C;
  localparam logic [7:0] OFS_RDATA = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_RESULT = 8'h18;
  localparam int CTRL_CD_BIT = 0;
  localparam int CTRL_NW_BIT = 1;
  localparam int CTRL_STRAP_BIT = 2;
  localparam int MOVE_DIR_BIT = 4;
  localparam logic [3:0] RESET_HOLD = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: cache_test_if.sv
/*
  link between the cache test logic and the core that drives it.
  assumes both ends run on the same aclk.
*/
`timescale 1ns/1ps
interface cache_test_if;
  logic proc_reset;
  logic addr_hold_pin;
  logic cache_disable_bit;
  logic no_writethrough_bit;
  logic treg_wr;
  logic treg_rd;
  logic [1:0] treg_sel;
  logic [31:0] treg_wdata;
  logic [31:0] treg_rdata;
  logic treg_ack;
  logic bus_cycle_allow;
  logic selftest_busy;
  logic core_running;
  logic [31:0] acc_result;

  modport dev (
    input proc_reset, addr_hold_pin, cache_disable_bit, no_writethrough_bit,
    input treg_wr, treg_rd, treg_sel, treg_wdata,
    output treg_rdata, treg_ack, bus_cycle_allow, selftest_busy, core_running, acc_result
  );
  modport host (
    output proc_reset, addr_hold_pin, cache_disable_bit, no_writethrough_bit,
    output treg_wr, treg_rd, treg_sel, treg_wdata,
    input treg_rdata, treg_ack, bus_cycle_allow, selftest_busy, core_running, acc_result
  );
endinterface

// File: cache_test_device.sv
/*
  cache test registers, cache arrays and power-on self check sequencer.
  assumes the core holds proc_reset high for some cycles and issues test
  register moves as a level request held until treg_ack.
*/
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
// Behaviour
// R1: strap high the clock before reset falls
// R2: self check lasts about a million clocks
// R3: no bus cycle during self check
// R4: result in accumulator, zero means pass
// R5: reset sequence then normal run afterwards
// R6: check logic, rom, cache, translation buffer
// R7: write, read, compare all 512 entries
// R8: 128-bit fill and read buffers
// R9: four word accesses per buffer
// R10: tag/status holds tag, valid, lru, set valids
// R11: seven-bit set select picks set
// R12: entry select picks word or way
// R13: control field decodes four operations
// R14: software sets cd and nw first
// R15: data write fills chosen fill word
// R16: software loads tag and valid first
// R17: control 01 writes line, tag, valid
// R18: testability write updates set lru
// R19: cache writes only with replacement disabled
// R20: data read returns chosen read word
// R21: flush clears lru and valid only
// R22: software drains buffers before memory use
// R23: control 10 loads read buffer, status
`timescale 1ns/1ps
module cache_test_device #(
  parameter int SELFTEST_CYCLES = cache_test_pkg::ST_CYCLES
)(
  input wire logic aclk,
  input wire logic aresetn,
  cache_test_if.dev tif,
  output logic core_running,
  output logic [31:0] selftest_result
);
  typedef enum logic [3:0] {
    S_HOLD, S_LOGIC, S_ROM, S_CWR, S_CRD, S_TLB, S_PAD, S_RESEQ, S_RUN
  } st_t;
  localparam int IDX_W = cache_test_pkg::IDX_W;
  localparam int CYC_W = cache_test_pkg::CYC_W;
  localparam int TAG_W = cache_test_pkg::TAG_W;

  st_t state_reg;
  logic [cache_test_pkg::CYC_W-1:0] cyc_reg;
  logic [cache_test_pkg::IDX_W-1:0] idx_reg;
  logic pass_reg;
  logic strap_reg;
  logic [3:0] flaw_reg;
  logic [31:0] rom_sig_reg;
  logic [31:0] acc_reg;
  logic [cache_test_pkg::LINE_W-1:0] data_mem [cache_test_pkg::ENTRIES];
  logic [cache_test_pkg::TAG_W-1:0] tag_mem [cache_test_pkg::ENTRIES];
  logic [cache_test_pkg::TLB_W-1:0] tlb_mem [cache_test_pkg::TLB_ENTRIES];
  logic [cache_test_pkg::ENTRIES-1:0] valid_reg;
  logic [cache_test_pkg::LRU_W-1:0] lru_reg [cache_test_pkg::SETS];
  logic [cache_test_pkg::LINE_W-1:0] fill_reg;
  logic [cache_test_pkg::LINE_W-1:0] rbuf_reg;
  logic [31:0] cmd_reg;
  logic [31:0] ts_reg;
  logic [31:0] rdata_reg;
  logic ack_reg;
  logic take_wr;
  logic take_rd;
  logic cmd_wr;
  logic op_write;
  logic op_read;
  logic op_flush;
  logic [1:0] w_ctl;
  logic [1:0] w_ent;
  logic [cache_test_pkg::SET_W-1:0] w_set;
  logic [cache_test_pkg::LOC_W-1:0] w_loc;
  logic [1:0] cur_ent;
  logic [1:0] cur_ctl;
  logic [cache_test_pkg::LOC_W-1:0] st_loc;
  logic [31:0] st_word;
  logic [cache_test_pkg::LINE_W-1:0] st_line;
  logic [7:0] lg_val;
  logic [4:0] tlb_loc;
  logic [cache_test_pkg::TLB_W-1:0] tlb_pat;

  // pseudo-lru: bit0 picks the pair, bit1/bit2 the way inside it
  function automatic logic [2:0] lru_touch(input logic [2:0] l, input logic [1:0] way);
    logic [2:0] n;
    n = l;
    n[0] = ~way[1];
    if (way[1])
      n[2] = ~way[0];
    else
      n[1] = ~way[0];
    return n;
  endfunction

  // request decode; a held request is taken once, on the cycle after no ack
  assign take_wr = tif.treg_wr && !ack_reg && state_reg == S_RUN;
  assign take_rd = tif.treg_rd && !ack_reg && state_reg == S_RUN;
  assign cmd_wr = take_wr && tif.treg_sel == cache_test_pkg::SEL_CMD;
  assign w_ctl = tif.treg_wdata[cache_test_pkg::CMD_CTL_LSB +: 2];
  assign w_ent = tif.treg_wdata[cache_test_pkg::CMD_ENT_LSB +: 2]; // R12
  assign w_set = tif.treg_wdata[cache_test_pkg::CMD_SET_LSB +: cache_test_pkg::SET_W]; // R11
  assign w_loc = {w_set, w_ent};
  assign cur_ctl = cmd_reg[cache_test_pkg::CMD_CTL_LSB +: 2];
  assign cur_ent = cmd_reg[cache_test_pkg::CMD_ENT_LSB +: 2];
  // a write is only honoured with replacements disabled
  assign op_write = cmd_wr && w_ctl == cache_test_pkg::CTL_WRITE && tif.cache_disable_bit; // R13 R19 R14
  assign op_read = cmd_wr && w_ctl == cache_test_pkg::CTL_READ; // R13
  assign op_flush = cmd_wr && w_ctl == cache_test_pkg::CTL_FLUSH; // R13

  // self check patterns, changed per pass
  assign st_loc = idx_reg[cache_test_pkg::LOC_W-1:0];
  assign st_word = (pass_reg ? cache_test_pkg::PAT_B : cache_test_pkg::PAT_A) ^ 32'(st_loc);
  assign st_line = {cache_test_pkg::WAYS{st_word}};
  assign lg_val = idx_reg[7:0];
  assign tlb_loc = idx_reg[4:0];
  // keyed by slot only, so the write and read-back halves see one pattern
  assign tlb_pat = cache_test_pkg::TLB_W'(cache_test_pkg::PAT_A ^ 32'(tlb_loc));

  // data and tag arrays: self check owns the port while it runs
  always_ff @(posedge aclk)
  begin
    if (state_reg == S_CWR)
    begin
      data_mem[st_loc] <= st_line; // R7
      tag_mem[st_loc] <= cache_test_pkg::TAG_W'(st_word);
    end
    else if (op_write)
    begin
      data_mem[w_loc] <= fill_reg; // R17
      tag_mem[w_loc] <= ts_reg[cache_test_pkg::TS_TAG_LSB +: cache_test_pkg::TAG_W]; // R17
    end
    if (state_reg == S_TLB && !idx_reg[5])
      tlb_mem[tlb_loc] <= tlb_pat;
  end

  // valid and lru state; flush leaves data and tags alone
  always_ff @(posedge aclk)
  begin
    if (!aresetn || tif.proc_reset || op_flush || state_reg == S_RESEQ) // R21
    begin
      valid_reg <= '0;
      for (int i = 0; i < cache_test_pkg::SETS; i++)
        lru_reg[i] <= '0;
    end
    else if (op_write)
    begin
      valid_reg[w_loc] <= ts_reg[cache_test_pkg::TS_VALID_BIT]; // R17
      lru_reg[w_set] <= lru_touch(lru_reg[w_set], w_ent); // R18
    end
  end

  // test registers and the buffers behind the data window
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fill_reg <= '0;
      rbuf_reg <= '0;
      cmd_reg <= '0;
      ts_reg <= '0;
      rdata_reg <= '0;
      ack_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= take_wr || take_rd;
      if (take_wr)
      begin
        case (tif.treg_sel)
          cache_test_pkg::SEL_DATA:
            if (cur_ctl == cache_test_pkg::CTL_BUF)
              fill_reg[32 * int'(cur_ent) +: 32] <= tif.treg_wdata; // R15 R8 R9
          cache_test_pkg::SEL_TAG: ts_reg <= tif.treg_wdata; // R16
          cache_test_pkg::SEL_CMD: cmd_reg <= tif.treg_wdata;
          default: ;
        endcase
      end
      if (op_read)
      begin
        rbuf_reg <= data_mem[w_loc]; // R23
        ts_reg <= {tag_mem[w_loc], valid_reg[w_loc], lru_reg[w_set],
          valid_reg[{w_set, 2'h0} +: cache_test_pkg::WAYS], 3'h0}; // R10 R23
      end
      if (take_rd)
      begin
        case (tif.treg_sel)
          cache_test_pkg::SEL_DATA:
            rdata_reg <= (cur_ctl == cache_test_pkg::CTL_BUF) ?
              rbuf_reg[32 * int'(cur_ent) +: 32] : 32'h00000000; // R20 R9
          cache_test_pkg::SEL_TAG: rdata_reg <= ts_reg;
          cache_test_pkg::SEL_CMD: rdata_reg <= cmd_reg;
          default: rdata_reg <= 32'h00000000;
        endcase
      end
    end
  end

  // self check sequencer; the strap is caught every cycle reset is high,
  // so the value kept is the one from the clock before reset falls
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= S_HOLD;
      strap_reg <= 1'b0;
      cyc_reg <= '0;
      idx_reg <= '0;
      pass_reg <= 1'b0;
      flaw_reg <= '0;
      rom_sig_reg <= '0;
      acc_reg <= '0;
    end
    else if (tif.proc_reset)
    begin
      state_reg <= S_HOLD;
      strap_reg <= tif.addr_hold_pin; // R1
      cyc_reg <= '0;
      idx_reg <= '0;
      pass_reg <= 1'b0;
      flaw_reg <= '0;
      rom_sig_reg <= '0;
    end
    else
    begin
      cyc_reg <= cyc_reg + 1'b1;
      idx_reg <= idx_reg + 1'b1;
      case (state_reg)
        S_HOLD:
        begin
          idx_reg <= '0;
          state_reg <= strap_reg ? S_LOGIC : S_RESEQ;
        end
        S_LOGIC: // R6
        begin
          if (8'(lg_val + ~lg_val) != 8'hFF)
            flaw_reg[cache_test_pkg::FLAW_LOGIC] <= 1'b1;
          if (idx_reg == IDX_W'(cache_test_pkg::LOGIC_STEPS - 1))
          begin
            idx_reg <= '0;
            state_reg <= S_ROM;
          end
        end
        S_ROM: // R6
        begin
          rom_sig_reg <= rom_sig_reg ^ cache_test_pkg::ROM_IMG[idx_reg[1:0]];
          if (idx_reg == IDX_W'(cache_test_pkg::ROM_WORDS - 1))
          begin
            if ((rom_sig_reg ^ cache_test_pkg::ROM_IMG[idx_reg[1:0]]) != cache_test_pkg::ROM_SIG)
              flaw_reg[cache_test_pkg::FLAW_ROM] <= 1'b1;
            idx_reg <= '0;
            state_reg <= S_CWR;
          end
        end
        S_CWR:
          if (idx_reg == IDX_W'(cache_test_pkg::ENTRIES - 1))
          begin
            idx_reg <= '0;
            state_reg <= S_CRD;
          end
        S_CRD: // R7
        begin
          if (data_mem[st_loc] != st_line || tag_mem[st_loc] != TAG_W'(st_word))
            flaw_reg[cache_test_pkg::FLAW_CACHE] <= 1'b1;
          if (idx_reg == IDX_W'(cache_test_pkg::ENTRIES - 1))
          begin
            idx_reg <= '0;
            pass_reg <= 1'b1;
            state_reg <= pass_reg ? S_TLB : S_CWR;
          end
        end
        S_TLB: // R6
        begin
          if (idx_reg[5] && tlb_mem[tlb_loc] != tlb_pat)
            flaw_reg[cache_test_pkg::FLAW_TLB] <= 1'b1;
          if (idx_reg == IDX_W'(2 * cache_test_pkg::TLB_ENTRIES - 1))
            state_reg <= S_PAD;
        end
        S_PAD: // R2
          if (cyc_reg >= CYC_W'(SELFTEST_CYCLES - 1))
          begin
            acc_reg <= 32'(flaw_reg); // R4
            idx_reg <= '0;
            state_reg <= S_RESEQ;
          end
        S_RESEQ: // R5
          if (idx_reg == IDX_W'(cache_test_pkg::RESEQ_CYCLES - 1))
            state_reg <= S_RUN;
        S_RUN:
          idx_reg <= '0;
        default:
          state_reg <= S_HOLD;
      endcase
    end
  end

  // bus cycles start only in normal run, never during the check
  assign tif.bus_cycle_allow = state_reg == S_RUN; // R3
  assign tif.selftest_busy = state_reg != S_RUN && state_reg != S_HOLD && state_reg != S_RESEQ;
  assign tif.core_running = state_reg == S_RUN;
  assign tif.treg_ack = ack_reg;
  assign tif.treg_rdata = rdata_reg;
  assign tif.acc_result = acc_reg;
  assign core_running = state_reg == S_RUN;
  assign selftest_result = acc_reg;
endmodule

// File: cache_test_host.sv
/*
  controller end: an axi4-lite slave whose registers drive the core side
  of the cache test link (reset with strap, mode bits, test register moves).
  assumes a single aclk shared with the device end.
*/
`timescale 1ns/1ps
module cache_test_host (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  cache_test_if.host tif
);
  logic aw_got_reg;
  logic w_got_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdat_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg;
  logic bvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic rvalid_reg;
  logic [2:0] ctrl_reg;
  logic [31:0] move_reg;
  logic [31:0] mdata_reg;
  logic [31:0] mres_reg;
  logic [3:0] rst_cnt_reg;
  logic req_wr_reg;
  logic req_rd_reg;
  logic do_wr;
  logic [31:0] wmask;
  logic mv_start;

  assign do_wr = aw_got_reg && w_got_reg && !bvalid_reg;
  assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  assign mv_start = do_wr && awaddr_reg == cache_test_pkg::OFS_MOVE && !req_wr_reg && !req_rd_reg;
  assign awready = !aw_got_reg && !bvalid_reg;
  assign wready = !w_got_reg && !bvalid_reg;
  assign arready = !rvalid_reg;

  // address and data are caught separately, in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= '0;
      wdat_reg <= '0;
      wstrb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= cache_test_pkg::RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_got_reg <= 1'b1;
        wdat_reg <= wdata;
        wstrb_reg <= wstrb;
      end
      if (do_wr)
      begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= (awaddr_reg == cache_test_pkg::OFS_CTRL || awaddr_reg == cache_test_pkg::OFS_RESET
          || awaddr_reg == cache_test_pkg::OFS_MOVE || awaddr_reg == cache_test_pkg::OFS_WDATA) ?
          cache_test_pkg::RESP_OKAY : cache_test_pkg::RESP_SLVERR;
      end
      else if (bvalid_reg && bready)
        bvalid_reg <= 1'b0;
    end
  end

  // controller registers and the move request; a move written while one is
  // pending is dropped rather than queued
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg <= '0;
      move_reg <= '0;
      mdata_reg <= '0;
      mres_reg <= '0;
      rst_cnt_reg <= cache_test_pkg::RESET_HOLD;
      req_wr_reg <= 1'b0;
      req_rd_reg <= 1'b0;
    end
    else
    begin
      if (rst_cnt_reg != 4'h0)
        rst_cnt_reg <= rst_cnt_reg - 4'h1;
      if (do_wr && awaddr_reg == cache_test_pkg::OFS_CTRL)
        ctrl_reg <= 3'((32'(ctrl_reg) & ~wmask) | (wdat_reg & wmask));
      if (do_wr && awaddr_reg == cache_test_pkg::OFS_RESET)
        rst_cnt_reg <= cache_test_pkg::RESET_HOLD;
      if (do_wr && awaddr_reg == cache_test_pkg::OFS_WDATA)
        mdata_reg <= (mdata_reg & ~wmask) | (wdat_reg & wmask);
      if (mv_start)
      begin
        move_reg <= wdat_reg;
        req_wr_reg <= !wdat_reg[cache_test_pkg::MOVE_DIR_BIT];
        req_rd_reg <= wdat_reg[cache_test_pkg::MOVE_DIR_BIT];
      end
      else if (tif.treg_ack)
      begin
        req_wr_reg <= 1'b0;
        req_rd_reg <= 1'b0;
        if (req_rd_reg)
          mres_reg <= tif.treg_rdata;
      end
    end
  end

  // read channel answers one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= cache_test_pkg::RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg <= cache_test_pkg::RESP_OKAY;
      case (araddr)
        cache_test_pkg::OFS_CTRL: rdata_reg <= 32'(ctrl_reg);
        cache_test_pkg::OFS_RESET: rdata_reg <= 32'(tif.proc_reset);
        cache_test_pkg::OFS_MOVE: rdata_reg <= move_reg;
        cache_test_pkg::OFS_WDATA: rdata_reg <= mdata_reg;
        cache_test_pkg::OFS_RDATA: rdata_reg <= mres_reg;
        cache_test_pkg::OFS_STATUS:
          rdata_reg <= 32'({tif.proc_reset, tif.core_running, tif.selftest_busy,
            req_wr_reg | req_rd_reg});
        cache_test_pkg::OFS_RESULT: rdata_reg <= tif.acc_result;
        default:
        begin
          rdata_reg <= 32'h00000000;
          rresp_reg <= cache_test_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_reg && rready)
      rvalid_reg <= 1'b0;
  end

  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  // strap only drives while reset is held, so its last value is the pre-release clock
  assign tif.proc_reset = rst_cnt_reg != 4'h0;
  assign tif.addr_hold_pin = ctrl_reg[cache_test_pkg::CTRL_STRAP_BIT] && rst_cnt_reg != 4'h0; // R1
  assign tif.cache_disable_bit = ctrl_reg[cache_test_pkg::CTRL_CD_BIT];
  assign tif.no_writethrough_bit = ctrl_reg[cache_test_pkg::CTRL_NW_BIT];
  assign tif.treg_wr = req_wr_reg;
  assign tif.treg_rd = req_rd_reg;
  assign tif.treg_sel = move_reg[1:0];
  assign tif.treg_wdata = mdata_reg;
endmodule

// File: cache_test_sva.sv
/*
  assertions on the link between the host and device ends of the cache test logic.
  assumes one aclk and a synchronous active-low aresetn; instantiated beside the link.
*/
`timescale 1ns/1ps
module cache_test_sva #(
  parameter int SELFTEST_CYCLES = 3000
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic proc_reset,
  input wire logic addr_hold_pin,
  input wire logic treg_wr,
  input wire logic treg_rd,
  input wire logic treg_ack,
  input wire logic bus_cycle_allow,
  input wire logic selftest_busy,
  input wire logic core_running,
  input wire logic [31:0] acc_result
);
  int busy_cnt;
  // length of the running self check; idle clears it so a second run starts fresh
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !selftest_busy)
      busy_cnt <= 0;
    else
      busy_cnt <= busy_cnt + 1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // reset release with and without the strap
  sequence strap_rel_s;
    $past(addr_hold_pin) && $fell(proc_reset);
  endsequence
  sequence plain_rel_s;
    !$past(addr_hold_pin) && $fell(proc_reset);
  endsequence
  strap_in_reset_a: assert property (addr_hold_pin |-> proc_reset)
    else $error("strap driven outside reset");
  strap_starts_a: assert property (strap_rel_s |-> ##[1:3] selftest_busy)
    else $error("self check not started after strapped reset");
  check_length_a: assert property ($fell(selftest_busy) |->
    busy_cnt >= SELFTEST_CYCLES - 16 && busy_cnt <= SELFTEST_CYCLES + 16)
    else $error("self check length wrong");
  quiet_bus_a: assert property (selftest_busy |-> !bus_cycle_allow)
    else $error("bus cycle allowed during self check");
  result_hold_a: assert property (core_running && $past(core_running) |-> $stable(acc_result))
    else $error("result word moved in normal run");
  rerun_after_a: assert property ($fell(selftest_busy) |-> ##[1:24] core_running)
    else $error("no normal run after self check");
  plain_boot_a: assert property (plain_rel_s |-> !selftest_busy throughout ##[15:20] core_running)
    else $error("reset sequence length wrong");
  ack_cause_a: assert property (treg_ack |-> ($past(treg_wr) || $past(treg_rd)) && $past(core_running))
    else $error("move ack without request");
  ack_pulse_a: assert property (treg_ack |=> !treg_ack)
    else $error("move ack longer than one cycle");
endmodule

// File: testbench.sv
/*
  self-checking bench: host and device joined by the link, driven over axi4-lite.
  assumes a 100 MHz aclk and a shortened self check.
*/
`timescale 1ns/1ps
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin err_total++; \
  $display("unexpected %s expected %h seen %h", nm, e, s); end end
module testbench;
  localparam int ST = 3000;
  localparam logic [31:0] TAGV = 32'h091A2C00;
  typedef struct {logic [1:0] sel; logic rd; logic [31:0] d; logic [31:0] e;} row_t;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000, rdata, q, dev_result;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, dev_running;
  logic [1:0] bresp, rresp, resp;
  int err_total = 0, compares = 0, i;
  row_t rows[$];
  cache_test_if tif();
  always #5 aclk = ~aclk;
  cache_test_host u_cache_test_host (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .tif(tif.host));
  cache_test_device #(.SELFTEST_CYCLES(ST)) u_cache_test_device (.aclk(aclk),
    .aresetn(aresetn), .tif(tif.dev), .core_running(dev_running), .selftest_result(dev_result));
  cache_test_sva #(.SELFTEST_CYCLES(ST)) u_cache_test_sva (.aclk(aclk), .aresetn(aresetn),
    .proc_reset(tif.proc_reset), .addr_hold_pin(tif.addr_hold_pin), .treg_wr(tif.treg_wr),
    .treg_rd(tif.treg_rd), .treg_ack(tif.treg_ack), .bus_cycle_allow(tif.bus_cycle_allow),
    .selftest_busy(tif.selftest_busy), .core_running(tif.core_running),
    .acc_result(tif.acc_result));
  task automatic summarize();
    $display("mismatches %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic expire(input string nm);
    err_total++;
    $display("unexpected %s wait expected %h seen %h", nm, 1'h1, 1'h0);
    summarize();
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    bready <= 1'h0;
    resp = bresp;
    if (n == 64) expire("write");
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    rready <= 1'h0;
    q = rdata;
    resp = rresp;
    if (n == 64) expire("read");
  endtask
  // one test register move; the move pending bit is polled since the link answers at its own pace
  task automatic mv(input logic [1:0] s, input logic r, input logic [31:0] d);
    int n;
    wr(cache_test_pkg::OFS_WDATA, d);
    wr(cache_test_pkg::OFS_MOVE, {27'h0, r, 2'h0, s});
    for (n = 0; n < 32; n++)
    begin
      rd(cache_test_pkg::OFS_STATUS);
      if (q[0] === 1'h0) break;
    end
    if (n == 32) expire("move");
    if (r) rd(cache_test_pkg::OFS_RDATA);
  endtask
  // poll until the core runs, so a boot in progress cannot swallow the strap
  task automatic wait_run(input string nm);
    int n;
    for (n = 0; n < 4000; n++)
    begin
      rd(cache_test_pkg::OFS_STATUS);
      if (q[2] === 1'h1) break;
    end
    if (n == 4000) expire(nm);
  endtask
  function automatic void add(input logic [1:0] s, input logic r, input logic [31:0] d,
    input logic [31:0] e);
    rows.push_back(row_t'{s, r, d, e});
  endfunction
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    wait_run("boot");
    rd(cache_test_pkg::OFS_RESULT);
    `CHK("plain boot result", 32'h00000000, q)
    // strapped reset: self check, then normal run
    wr(cache_test_pkg::OFS_CTRL, 32'h00000007);
    wr(cache_test_pkg::OFS_RESET, 32'h00000000);
    wait_run("self check");
    rd(cache_test_pkg::OFS_RESULT);
    `CHK("self check result", 32'h00000000, q)
    `CHK("result pin", 32'h00000000, dev_result)
    `CHK("running pin", 1'h1, dev_running)
    // fill, write set 5 way 2, read back, drain, flush, read again
    for (i = 0; i < 4; i++)
    begin
      add(cache_test_pkg::SEL_CMD, 1'h0, i << 2, 32'h0);
      add(cache_test_pkg::SEL_DATA, 1'h0, 32'hC0DE0000 + i, 32'h0);
    end
    add(cache_test_pkg::SEL_TAG, 1'h0, TAGV, 32'h0);
    add(cache_test_pkg::SEL_CMD, 1'h0, 32'h00000059, 32'h0);
    add(cache_test_pkg::SEL_CMD, 1'h0, 32'h0000005A, 32'h0);
    add(cache_test_pkg::SEL_DATA, 1'h1, 32'h0, 32'h00000000);
    add(cache_test_pkg::SEL_TAG, 1'h1, 32'h0, TAGV | 32'h00000220);
    for (i = 0; i < 4; i++)
    begin
      add(cache_test_pkg::SEL_CMD, 1'h0, i << 2, 32'h0);
      add(cache_test_pkg::SEL_DATA, 1'h1, 32'h0, 32'hC0DE0000 + i);
    end
    add(cache_test_pkg::SEL_CMD, 1'h0, 32'h00000003, 32'h0);
    add(cache_test_pkg::SEL_CMD, 1'h0, 32'h0000005A, 32'h0);
    add(cache_test_pkg::SEL_TAG, 1'h1, 32'h0, 32'h091A2800);
    add(cache_test_pkg::SEL_CMD, 1'h0, 32'h00000000, 32'h0);
    add(cache_test_pkg::SEL_DATA, 1'h1, 32'h0, 32'hC0DE0000);
    foreach (rows[i])
    begin
      mv(rows[i].sel, rows[i].rd, rows[i].d);
      if (rows[i].rd) `CHK("move read", rows[i].e, q)
    end
    // cache write refused while replacements are enabled
    wr(cache_test_pkg::OFS_CTRL, 32'h00000000);
    mv(cache_test_pkg::SEL_CMD, 1'h0, 32'h00000059);
    wr(cache_test_pkg::OFS_CTRL, 32'h00000003);
    mv(cache_test_pkg::SEL_CMD, 1'h0, 32'h0000005A);
    mv(cache_test_pkg::SEL_TAG, 1'h1, 32'h0);
    `CHK("tag after refused write", 32'h091A2800, q)
    rd(8'h1C);
    `CHK("unmapped read resp", cache_test_pkg::RESP_SLVERR, resp)
    wr(cache_test_pkg::OFS_RDATA, 32'h0000FFFF);
    `CHK("read-only write resp", cache_test_pkg::RESP_SLVERR, resp)
    summarize();
  end
endmodule
